// File: core/rxofl_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxofl_defines.svh"

module rxofl_chan
	import rxofl_pkg::*;
#(
	parameter int unsigned HIGH_CYC = `RXOFL_CLK_HIGH_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Effective settings
	input wire logic single_rail,
	input wire logic clk_invert,
	input wire logic rx_off,
	input wire logic mute_active,
	input wire rxofl_lb_e lb_mode,
	// Line receive side
	input wire logic line_rx_plus,
	input wire logic line_rx_minus,
	input wire logic line_rx_bit_strobe,
	// Terminal transmit side
	input wire logic tx_pos_data_in,
	input wire logic tx_neg_data_in,
	input wire logic tx_clock_in,
	// Outputs
	output logic rx_pos_rail_out,
	output logic rx_neg_rail_out,
	output logic rx_recovered_clock_out,
	output logic line_tx_plus,
	output logic line_tx_minus
);

	// ======================================================================
	// Source selection.
	rxofl_ph_e ph_q, ph_d;
	logic [3:0] cnt_q;
	logic txc_q;
	wire tx_strobe = tx_clock_in & ~txc_q;
	wire local_lb = (lb_mode == LB_ANALOG) || (lb_mode == LB_DIGITAL);
	wire remote_lb = (lb_mode == LB_REMOTE);
	wire bit_strobe = local_lb ? tx_strobe : line_rx_bit_strobe;
	wire src_p = local_lb ? tx_pos_data_in : line_rx_plus;
	wire src_n = local_lb ? tx_neg_data_in : line_rx_minus;
	// An AMI pulse of either polarity is a decoded one.
	wire pos_d = single_rail ? (src_p | src_n) : src_p;
	wire neg_d = single_rail ? 1'b0 : src_n;
	wire hold_done = (cnt_q == 4'(HIGH_CYC - 1));

	// ======================================================================
	// Recovered clock phase.
	always_comb begin
		ph_d = ph_q;
		case (ph_q)
			PH_OFF: begin
				if (!rx_off) ph_d = PH_LOW;
			end
			PH_LOW: begin
				if (rx_off) ph_d = PH_OFF;
				else if (bit_strobe) ph_d = PH_HIGH;
			end
			PH_HIGH: begin
				if (rx_off) ph_d = PH_OFF;
				else if (bit_strobe) ph_d = PH_HIGH;
				else if (hold_done) ph_d = PH_LOW;
			end
			default: ph_d = PH_OFF;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_q <= PH_OFF;
			cnt_q <= 4'h0;
			txc_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
			txc_q <= tx_clock_in;
			cnt_q <= (bit_strobe || ph_q != PH_HIGH) ? 4'h0 : cnt_q + 4'h1;
		end
	end

	// ======================================================================
	// Data launches with the clock edge; inversion turns it into a fall.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_pos_rail_out <= 1'b0;
			rx_neg_rail_out <= 1'b0;
			rx_recovered_clock_out <= 1'b0;
		end else begin
			if (rx_off || mute_active) begin
				rx_pos_rail_out <= 1'b0;
				rx_neg_rail_out <= 1'b0;
			end else if (bit_strobe) begin
				rx_pos_rail_out <= pos_d;
				rx_neg_rail_out <= neg_d;
			end else if (single_rail) begin
				rx_neg_rail_out <= 1'b0;
			end
			rx_recovered_clock_out <= (ph_d == PH_OFF) ? 1'b0 :
				((ph_d == PH_HIGH) ^ clk_invert);
		end
	end

	// ======================================================================
	// Transmit line side keeps running in local loop-back.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_tx_plus <= 1'b0;
			line_tx_minus <= 1'b0;
		end else if (remote_lb) begin
			if (line_rx_bit_strobe) begin
				line_tx_plus <= line_rx_plus;
				line_tx_minus <= line_rx_minus;
			end
		end else if (tx_strobe) begin
			line_tx_plus <= tx_pos_data_in;
			line_tx_minus <= tx_neg_data_in;
		end
	end

endmodule

`default_nettype wire

// File: core/rxofl_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxofl_defines.svh"

// How it works
// - Data updates on recovered clock rising edge.
// - Recovered clock follows the received line bits.
// - Positive line pulse drives positive rail high.
// - Negative line pulse drives negative rail high.
// - Hardware invert pin moves launch to falling.
// - Host invert bit inverts the recovered clock.
// - Host format bit selects single-rail output.
// - Single-rail puts decoded data on positive rail.
// - Hardware format pin selects rail format globally.
// - Single-rail holds the negative rail low.
// - Hardware shutoff pin turns receivers off.
// - Host shutoff bit turns channel receiver off.
// - Four channels, each with its own loop-back.
// - Analog local loop feeds transmit into receive.
// - Transmit line output keeps running in analog loop.
// - Host local bit alone selects analog loop.
// - Hardware local pin alone selects analog loop.
// - Digital local loop feeds encoder into decoder.
// - Host both bits select digital local loop.
// - Host remote bit alone selects remote loop.
// - Muting forces both rails low during signal loss.
module rxofl_top
	import rxofl_pkg::*;
#(
	parameter int unsigned NCH = 4,
	parameter int unsigned HIGH_CYC = `RXOFL_CLK_HIGH_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [`RXOFL_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Mode and global hardware pins
	input wire logic host_mode,
	input wire logic global_clock_invert_pin,
	input wire logic rail_format_select,
	input wire logic receive_shutoff,
	input wire logic signal_loss_mute_enable,
	// Per-channel hardware loop-back pins
	input wire logic [NCH-1:0] local_loopback_select,
	input wire logic [NCH-1:0] remote_loopback_select,
	// Line receive side
	input wire logic [NCH-1:0] line_rx_plus,
	input wire logic [NCH-1:0] line_rx_minus,
	input wire logic [NCH-1:0] line_rx_bit_strobe,
	input wire logic [NCH-1:0] signal_loss_declared,
	// Terminal transmit side
	input wire logic [NCH-1:0] tx_pos_data_in,
	input wire logic [NCH-1:0] tx_neg_data_in,
	input wire logic [NCH-1:0] tx_clock_in,
	// Receive outputs to the terminal
	output logic [NCH-1:0] rx_pos_rail_out,
	output logic [NCH-1:0] rx_neg_rail_out,
	output logic [NCH-1:0] rx_recovered_clock_out,
	// Transmit line outputs
	output logic [NCH-1:0] line_tx_plus,
	output logic [NCH-1:0] line_tx_minus
);

	// ======================================================================
	// Address decode.
	localparam logic [1:0] SEL_RXCFG = 2'h0;
	localparam logic [1:0] SEL_LBCFG = 2'h1;
	localparam logic [1:0] SEL_STAT = 2'h2;
	localparam logic [1:0] SEL_NONE = 2'h3;

	// Channel index sits above the word offset; anything beyond is unmapped.
	function automatic logic [1:0] reg_select(input logic [`RXOFL_ADDR_W-1:0] a);
		logic [3:0] off;
		logic [`RXOFL_ADDR_W-1:0] ch;
		off = a[3:0];
		ch = a / `RXOFL_CH_STRIDE;
		if (ch >= `RXOFL_ADDR_W'(NCH)) return SEL_NONE;
		case (off)
			`RXOFL_OFF_RXCFG: return SEL_RXCFG;
			`RXOFL_OFF_LBCFG: return SEL_LBCFG;
			`RXOFL_OFF_STAT: return SEL_STAT;
			default: return SEL_NONE;
		endcase
	endfunction

	wire [1:0] sel = reg_select(paddr);
	wire [1:0] ch_idx = paddr[5:4];
	wire access = psel & penable;
	// One wait state: the answer is registered so every output is a flop.
	wire pready_d = access & ~pready;
	wire wr_fire = access & pready & pwrite;

	// ======================================================================
	// Configuration registers.
	logic [4:0] rxcfg_q [NCH];
	logic [4:0] lbcfg_q [NCH];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NCH; i++) begin
				rxcfg_q[i] <= `RXOFL_RXCFG_RST;
				lbcfg_q[i] <= `RXOFL_LBCFG_RST;
			end
		end else if (wr_fire) begin
			if (sel == SEL_RXCFG) rxcfg_q[ch_idx] <= pwdata[4:0] & `RXOFL_RXCFG_MASK;
			if (sel == SEL_LBCFG) lbcfg_q[ch_idx] <= pwdata[4:0] & `RXOFL_LBCFG_MASK;
		end
	end

	// ======================================================================
	// Effective per-channel settings: registers in host mode, pins otherwise.
	logic [NCH-1:0] eff_single;
	logic [NCH-1:0] eff_inv;
	logic [NCH-1:0] eff_off;
	logic [NCH-1:0] eff_mute_en;
	logic [NCH-1:0] mute_act;
	rxofl_lb_e eff_lb [NCH];

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			eff_single[i] = host_mode ? rxcfg_q[i][`RXOFL_RXCFG_SR] :
				rail_format_select;
			eff_inv[i] = host_mode ? rxcfg_q[i][`RXOFL_RXCFG_INV] :
				global_clock_invert_pin;
			eff_off[i] = host_mode ? rxcfg_q[i][`RXOFL_RXCFG_OFF] :
				receive_shutoff;
			eff_mute_en[i] = host_mode ? rxcfg_q[i][`RXOFL_RXCFG_MUTE] :
				signal_loss_mute_enable;
			mute_act[i] = eff_mute_en[i] & signal_loss_declared[i];
			eff_lb[i] = host_mode ?
				rxofl_lb_decode(lbcfg_q[i][`RXOFL_LBCFG_LLB],
					lbcfg_q[i][`RXOFL_LBCFG_RLB]) :
				rxofl_lb_decode(local_loopback_select[i],
					remote_loopback_select[i]);
		end
	end

	// ======================================================================
	// Read path: status reflects what the channel is really doing.
	function automatic logic [31:0] stat_word(input int i);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`RXOFL_STAT_LB_LO +: 2] = eff_lb[i];
		w[`RXOFL_STAT_SR] = eff_single[i];
		w[`RXOFL_STAT_OFF] = eff_off[i];
		w[`RXOFL_STAT_INV] = eff_inv[i];
		w[`RXOFL_STAT_MUTED] = mute_act[i];
		w[`RXOFL_STAT_LOS] = signal_loss_declared[i];
		return w;
	endfunction

	logic [31:0] rd_word;

	always_comb begin
		rd_word = 32'h0000_0000;
		case (sel)
			SEL_RXCFG: rd_word = {27'h0, rxcfg_q[ch_idx]};
			SEL_LBCFG: rd_word = {27'h0, lbcfg_q[ch_idx]};
			SEL_STAT: rd_word = stat_word(int'(ch_idx));
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= pready_d;
			pslverr <= pready_d & (sel == SEL_NONE);
			if (pready_d) prdata <= pwrite ? 32'h0000_0000 : rd_word;
		end
	end

	// ======================================================================
	// Channels.
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		rxofl_chan #(
			.HIGH_CYC(HIGH_CYC)
		) u_chan (
			.pclk(pclk),
			.presetn(presetn),
			.single_rail(eff_single[g]),
			.clk_invert(eff_inv[g]),
			.rx_off(eff_off[g]),
			.mute_active(mute_act[g]),
			.lb_mode(eff_lb[g]),
			.line_rx_plus(line_rx_plus[g]),
			.line_rx_minus(line_rx_minus[g]),
			.line_rx_bit_strobe(line_rx_bit_strobe[g]),
			.tx_pos_data_in(tx_pos_data_in[g]),
			.tx_neg_data_in(tx_neg_data_in[g]),
			.tx_clock_in(tx_clock_in[g]),
			.rx_pos_rail_out(rx_pos_rail_out[g]),
			.rx_neg_rail_out(rx_neg_rail_out[g]),
			.rx_recovered_clock_out(rx_recovered_clock_out[g]),
			.line_tx_plus(line_tx_plus[g]),
			.line_tx_minus(line_tx_minus[g])
		);
	end

	// ======================================================================
	// Checks. Helper state mirrors the transmit clock edge seen by a channel.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [NCH-1:0] txc_h_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) txc_h_q <= '0;
		else txc_h_q <= tx_clock_in;
	end

	a_apb_wait_one: assert property (access && !pready |=> pready)
		else $error("APB answer not given after one wait state");
	a_apb_err_map: assert property (pready_d && sel == SEL_NONE |=> pready && pslverr)
		else $error("unmapped access not flagged");

	for (genvar g = 0; g < NCH; g++) begin : g_chk
		wire is_local = (eff_lb[g] == LB_ANALOG) || (eff_lb[g] == LB_DIGITAL);
		wire tx_edge = tx_clock_in[g] & ~txc_h_q[g];
		wire strb = is_local ? tx_edge : line_rx_bit_strobe[g];
		wire live = !eff_off[g] && !mute_act[g];

		sequence s_line_bit;
			live && !is_local && line_rx_bit_strobe[g];
		endsequence

		sequence s_loop_bit;
			live && is_local && tx_edge && !eff_single[g];
		endsequence

		a_dual_pos_rail: assert property (s_line_bit and !eff_single[g]
			|=> rx_pos_rail_out[g] == $past(line_rx_plus[g]))
			else $error("positive rail does not follow line");
		a_dual_neg_rail: assert property (s_line_bit and !eff_single[g]
			|=> rx_neg_rail_out[g] == $past(line_rx_minus[g]))
			else $error("negative rail does not follow line");
		a_single_pos_data: assert property (s_line_bit and eff_single[g]
			|=> rx_pos_rail_out[g] == $past(line_rx_plus[g] | line_rx_minus[g]))
			else $error("single-rail data wrong");
		a_single_neg_low: assert property (eff_single[g] && !eff_off[g]
			|=> !rx_neg_rail_out[g])
			else $error("negative rail active in single-rail");
		a_launch_rise_edge: assert property (live && strb && !eff_inv[g]
			|=> rx_recovered_clock_out[g] && !$past(eff_inv[g]))
			else $error("data not launched with rising clock");
		a_launch_fall_edge: assert property (live && strb && eff_inv[g]
			|=> !rx_recovered_clock_out[g])
			else $error("inverted clock not low at launch");
		a_clock_from_line: assert property (!strb && !eff_inv[g] && !eff_off[g]
			&& !rx_recovered_clock_out[g] |=> !rx_recovered_clock_out[g])
			else $error("recovered clock rose with no received bit");
		a_rx_off_quiet: assert property (eff_off[g] |=> !rx_pos_rail_out[g]
			&& !rx_neg_rail_out[g] && !rx_recovered_clock_out[g])
			else $error("receive section active while shut off");
		a_mute_rails_low: assert property (mute_act[g]
			|=> !rx_pos_rail_out[g] && !rx_neg_rail_out[g])
			else $error("rails not muted during signal loss");
		a_local_loop_data: assert property (s_loop_bit
			|=> rx_pos_rail_out[g] == $past(tx_pos_data_in[g])
			&& rx_neg_rail_out[g] == $past(tx_neg_data_in[g]))
			else $error("local loop-back data mismatch");
		a_tx_keeps_going: assert property (eff_lb[g] != LB_REMOTE && tx_edge
			|=> line_tx_plus[g] == $past(tx_pos_data_in[g]))
			else $error("transmit line output stalled");
		a_remote_loop_tx: assert property (eff_lb[g] == LB_REMOTE
			&& line_rx_bit_strobe[g]
			|=> line_tx_minus[g] == $past(line_rx_minus[g]))
			else $error("remote loop-back transmit mismatch");
	end

endmodule

`default_nettype wire

// File: pkg/rxofl_defines.svh
`ifndef RXOFL_DEFINES_SVH
`define RXOFL_DEFINES_SVH

// ==========================================================================
// Register map: one block of words per channel.
`define RXOFL_ADDR_W 8
`define RXOFL_CH_STRIDE 8'h10
`define RXOFL_OFF_RXCFG 4'h0
`define RXOFL_OFF_LBCFG 4'h4
`define RXOFL_OFF_STAT 4'h8

// ==========================================================================
// Receive output configuration fields and reset value.
`define RXOFL_RXCFG_SR 4
`define RXOFL_RXCFG_MUTE 3
`define RXOFL_RXCFG_OFF 2
`define RXOFL_RXCFG_INV 1
`define RXOFL_RXCFG_MASK 5'h1E
`define RXOFL_RXCFG_RST 5'h00

// ==========================================================================
// Loop-back and rate configuration fields and reset value.
`define RXOFL_LBCFG_STS1 3
`define RXOFL_LBCFG_E3 2
`define RXOFL_LBCFG_LLB 1
`define RXOFL_LBCFG_RLB 0
`define RXOFL_LBCFG_MASK 5'h0F
`define RXOFL_LBCFG_RST 5'h00

// ==========================================================================
// Status word fields.
`define RXOFL_STAT_LB_LO 0
`define RXOFL_STAT_SR 2
`define RXOFL_STAT_OFF 3
`define RXOFL_STAT_INV 4
`define RXOFL_STAT_MUTED 5
`define RXOFL_STAT_LOS 6

// ==========================================================================
// Timing: line rates in kHz and the recovered clock high time.
`define RXOFL_PCLK_PS 5000
`define RXOFL_E3_KHZ 34368
`define RXOFL_DS3_KHZ 44736
`define RXOFL_STS1_KHZ 51840
`define RXOFL_STS1_HALF_PS (500000000 / `RXOFL_STS1_KHZ)
`define RXOFL_CLK_HIGH_RAW (`RXOFL_STS1_HALF_PS / `RXOFL_PCLK_PS)
`define RXOFL_CLK_HIGH_CYC ((`RXOFL_CLK_HIGH_RAW < 1) ? 1 : `RXOFL_CLK_HIGH_RAW)

`endif

// File: pkg/rxofl_pkg.sv
// ==========================================================================
// Types shared by the channel datapath and the register front end.
package rxofl_pkg;

	typedef enum logic [1:0] {
		LB_NORMAL = 2'b00,
		LB_REMOTE = 2'b01,
		LB_ANALOG = 2'b10,
		LB_DIGITAL = 2'b11
	} rxofl_lb_e;

	typedef enum logic [1:0] {
		PH_OFF = 2'b00,
		PH_LOW = 2'b01,
		PH_HIGH = 2'b10
	} rxofl_ph_e;

	// Local bit is the high bit of the code, remote the low one.
	function automatic rxofl_lb_e rxofl_lb_decode(input logic llb, input logic rlb);
		return rxofl_lb_e'({llb, rlb});
	endfunction

endpackage

// File: test/rxofl_term_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Terminal equipment: drives the transmit rails and counts clock edges.
module rxofl_term_model (
	// Clock
	input wire logic pclk,
	// Recovered clocks from the block
	input wire logic [3:0] rx_clk,
	// Transmit side into the block
	output logic [3:0] tx_pos,
	output logic [3:0] tx_neg,
	output logic [3:0] tx_clk
);
	logic [3:0] clk_q = 4'h0;
	int unsigned edge_cnt [4] = '{default: 0};

	initial begin
		tx_pos = 4'h0;
		tx_neg = 4'h0;
		tx_clk = 4'h0;
	end

	always @(posedge pclk) begin
		clk_q <= rx_clk;
		for (int i = 0; i < 4; i++) begin
			if (rx_clk[i] !== clk_q[i]) begin
				edge_cnt[i]++;
			end
		end
	end

	task automatic send(input int ch, input logic p, input logic n);
		@(posedge pclk);
		tx_pos[ch] <= p;
		tx_neg[ch] <= n;
		tx_clk[ch] <= 1'h1;
		repeat (2) @(posedge pclk);
		tx_clk[ch] <= 1'h0;
		// Hold time is over: show the opposite level so stale data cannot pass.
		tx_pos[ch] <= ~p;
		tx_neg[ch] <= ~n;
	endtask
endmodule
`default_nettype wire

// File: test/rxofl_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED at %0t got %0h exp %0h", $time, (a), (e)); end end
module rxofl_top_tb;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic host_mode = 1'h1;
	logic gcinv = 1'h1;
	logic rfs = 1'h1;
	logic rso = 1'h0;
	logic smute = 1'h0;
	logic [3:0] lls = 4'h0;
	logic [3:0] rls = 4'h0;
	logic [3:0] lrp = 4'h0;
	logic [3:0] lrm = 4'h0;
	logic [3:0] lrs = 4'h0;
	logic [3:0] sld = 4'h0;
	logic [3:0] txp, txn, txc, rxp, rxn, rxc, ltp, ltm;
	int n_checks = 0;
	int n_mismatch = 0;

	always #2.5 pclk = ~pclk;

	rxofl_top #(.NCH(4), .HIGH_CYC(1)) rxofl_top_inst (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .host_mode(host_mode), .global_clock_invert_pin(gcinv),
		.rail_format_select(rfs), .receive_shutoff(rso), .signal_loss_mute_enable(smute),
		.local_loopback_select(lls), .remote_loopback_select(rls), .line_rx_plus(lrp),
		.line_rx_minus(lrm), .line_rx_bit_strobe(lrs), .signal_loss_declared(sld),
		.tx_pos_data_in(txp), .tx_neg_data_in(txn), .tx_clock_in(txc),
		.rx_pos_rail_out(rxp), .rx_neg_rail_out(rxn), .rx_recovered_clock_out(rxc),
		.line_tx_plus(ltp), .line_tx_minus(ltm));

	rxofl_term_model rxofl_term_model_inst (
		.pclk(pclk), .rx_clk(rxc), .tx_pos(txp), .tx_neg(txn), .tx_clk(txc));

	// ==========================================================================
	// Bus and stimulus helpers.
	task automatic summarize();
		if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic hang();
		n_mismatch++;
		summarize();
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err);
		int i;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Look mid-cycle; the edge that follows a high ready completes the transfer.
		for (i = 0; i < 16; i++) begin
			#1;
			if (pready === 1'h1) break;
			@(posedge pclk);
		end
		if (i == 16) hang();
		q = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'h1, a, d, q, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'h0, a, 32'h0, q, e);
		`CHK(e, xe)
		if (!xe) `CHK(q, x)
	endtask

	task automatic tick();
		@(posedge pclk);
		#1;
	endtask

	// Outputs are settled on return: just after the edge that takes the strobe.
	task automatic strobe(input int ch, input logic p, input logic m);
		@(posedge pclk);
		lrp[ch] <= p;
		lrm[ch] <= m;
		lrs[ch] <= 1'h1;
		@(posedge pclk);
		lrs[ch] <= 1'h0;
		lrp[ch] <= ~p;
		lrm[ch] <= ~m;
		#1;
	endtask

	task automatic loop_send(input int ch, input logic p, input logic m);
		int i;
		fork
			rxofl_term_model_inst.send(ch, p, m);
			begin
				for (i = 0; i < 16; i++) begin
					tick();
					if (rxc[ch] === 1'h1) break;
				end
				if (i == 16) hang();
			end
		join
		#1;
	endtask

	// ==========================================================================
	// Scenarios.
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		for (int c = 0; c < 4; c++) begin
			rd_chk(8'(c * 16), 32'h0, 1'h0);
			rd_chk(8'(c * 16 + 4), 32'h0, 1'h0);
		end
		wr(8'h30, 32'h1F);
		rd_chk(8'h30, 32'h1E, 1'h0);
		wr(8'h34, 32'h1F);
		rd_chk(8'h34, 32'h0F, 1'h0);
		wr(8'h30, 32'h0);
		wr(8'h34, 32'h0);
		wr(8'h08, 32'h7F);
		rd_chk(8'h08, 32'h0, 1'h0);
		rd_chk(8'h40, 32'h0, 1'h1);
		apb(1'h1, 8'h0C, 32'h1, q, e);
		`CHK(e, 1'h1)
	endtask

	task automatic t_rails();
		strobe(0, 1'h1, 1'h0);
		`CHK({rxp[0], rxn[0], rxc[0]}, 3'h5)
		tick();
		`CHK({rxp[0], rxc[0]}, 2'h2)
		strobe(0, 1'h0, 1'h1);
		`CHK({rxp[0], rxn[0], rxc[0]}, 3'h3)
		wr(8'h00, 32'h10);
		strobe(0, 1'h0, 1'h1);
		`CHK({rxp[0], rxn[0]}, 2'h2)
		strobe(0, 1'h1, 1'h0);
		`CHK({rxp[0], rxn[0]}, 2'h2)
		wr(8'h00, 32'h02);
		strobe(0, 1'h1, 1'h0);
		`CHK({rxp[0], rxc[0]}, 2'h2)
		tick();
		`CHK(rxc[0], 1'h1)
		wr(8'h00, 32'h04);
		strobe(0, 1'h1, 1'h1);
		`CHK({rxp[0], rxn[0], rxc[0]}, 3'h0)
		rd_chk(8'h08, 32'h08, 1'h0);
		wr(8'h00, 32'h08);
		sld[0] <= 1'h1;
		strobe(0, 1'h1, 1'h1);
		`CHK({rxp[0], rxn[0], rxc[0]}, 3'h1)
		sld[0] <= 1'h0;
		strobe(0, 1'h1, 1'h0);
		`CHK({rxp[0], rxn[0]}, 2'h2)
		wr(8'h00, 32'h0);
	endtask

	task automatic t_loops();
		for (int c = 0; c < 4; c++) begin
			for (int m = 0; m < 4; m++) begin
				wr(8'(c * 16 + 4), 32'(m));
				rd_chk(8'(c * 16 + 8), 32'(m), 1'h0);
			end
			wr(8'(c * 16 + 4), 32'h0);
		end
		for (int m = 2; m < 4; m++) begin
			wr(8'h04, 32'(m));
			loop_send(0, 1'h1, 1'h0);
			`CHK({rxp[0], rxn[0], ltp[0], ltm[0]}, 4'hA)
			strobe(0, 1'h0, 1'h1);
			`CHK({rxp[0], rxn[0]}, 2'h2)
			loop_send(0, 1'h0, 1'h1);
			`CHK({rxp[0], rxn[0], ltp[0], ltm[0]}, 4'h5)
		end
		wr(8'h04, 32'h1);
		strobe(0, 1'h1, 1'h0);
		`CHK({rxp[0], ltp[0], ltm[0]}, 3'h6)
		strobe(0, 1'h0, 1'h1);
		`CHK({rxn[0], ltp[0], ltm[0]}, 3'h5)
		wr(8'h04, 32'h0);
	endtask

	task automatic t_hw();
		@(posedge pclk);
		host_mode <= 1'h0;
		gcinv <= 1'h0;
		strobe(1, 1'h0, 1'h1);
		`CHK({rxp[1], rxn[1]}, 2'h2)
		rfs <= 1'h0;
		gcinv <= 1'h1;
		strobe(1, 1'h1, 1'h0);
		`CHK({rxp[1], rxc[1]}, 2'h2)
		tick();
		`CHK(rxc[1], 1'h1)
		gcinv <= 1'h0;
		smute <= 1'h1;
		sld[1] <= 1'h1;
		strobe(1, 1'h1, 1'h1);
		`CHK({rxp[1], rxn[1]}, 2'h0)
		smute <= 1'h0;
		sld[1] <= 1'h0;
		rso <= 1'h1;
		strobe(1, 1'h1, 1'h0);
		`CHK({rxp[1], rxc[1]}, 2'h0)
		rso <= 1'h0;
		strobe(1, 1'h1, 1'h0);
		`CHK(rxp[1], 1'h1)
		lls[2] <= 1'h1;
		loop_send(2, 1'h1, 1'h0);
		`CHK({rxp[2], ltp[2]}, 2'h3)
		lls[2] <= 1'h0;
	endtask

	// ==========================================================================
	// Main sequence.
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_rails();
		t_loops();
		t_hw();
		summarize();
	end
endmodule
`default_nettype wire
